// ===== clock_reset_gen_pkg.sv
// Package with the register map, field positions and reset values of the clock register bank.
package clock_reset_gen_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [3:0] OFS_PLL_MULTIPLIER = 4'h0;
  localparam logic [3:0] OFS_PLL_REF_DIVIDER = 4'h1;
  localparam logic [3:0] OFS_FACTORY_TEST_FLAGS = 4'h2;
  localparam logic [3:0] OFS_CLOCK_FLAGS = 4'h3;
  localparam logic [3:0] OFS_CLOCK_IRQ_ENABLE = 4'h4;
  localparam logic [3:0] OFS_CLOCK_SOURCE_SELECT = 4'h5;
  localparam logic [3:0] OFS_PLL_CONTROL = 4'h6;
  localparam logic [3:0] OFS_PERIODIC_IRQ_CONTROL = 4'h7;
  localparam logic [3:0] OFS_WATCHDOG_CONTROL = 4'h8;
  localparam logic [3:0] OFS_FACTORY_FORCE_BYPASS = 4'h9;
  localparam logic [3:0] OFS_FACTORY_TEST_CONTROL = 4'ha;
  localparam logic [3:0] OFS_WATCHDOG_SERVICE = 4'hb;

  // ----------------------------------------------------------------
  // Field widths and positions
  // ----------------------------------------------------------------
  localparam int MULT_W = 6;
  localparam int REFDIV_W = 4;
  localparam int BIT_PERIODIC_FLAG = 7;
  localparam int BIT_POWER_ON_FLAG = 6;
  localparam int BIT_LOW_VOLTAGE_FLAG = 5;
  localparam int BIT_LOCK_CHANGE_FLAG = 4;
  localparam int BIT_LOCK_STATUS = 3;
  localparam int BIT_TRACK_STATUS = 2;
  localparam int BIT_SELFCLOCK_CHANGE_FLAG = 1;
  localparam int BIT_SELFCLOCK_STATUS = 0;
  localparam int BIT_PERIODIC_ENABLE = 7;
  localparam int BIT_LOCK_CHANGE_ENABLE = 4;
  localparam int BIT_SELFCLOCK_CHANGE_ENABLE = 1;
  localparam int BIT_PLL_SOURCE_SELECT = 7;
  localparam int BIT_PLL_AUTO = 5;

  // ----------------------------------------------------------------
  // Implemented-bit masks and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] MASK_IRQ_ENABLE = 8'h92;
  localparam logic [7:0] MASK_PLL_CONTROL = 8'hf7;
  localparam logic [7:0] MASK_PERIODIC_CONTROL = 8'h7f;
  localparam logic [7:0] MASK_WATCHDOG_CONTROL = 8'hc7;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] RST_PLL_CONTROL = 8'h00;

endpackage

// ===== clock_gen_register_bank.sv
// Register bank, flag logic and clock-rate arithmetic of the clock and reset generator.
`timescale 1ns/100ps

// Behaviour
// [RULE1] PLL rate is twice oscillator rate times (multiplier+1) over (divider+1).
// [RULE2] Reference rate is oscillator rate divided by four-bit divider plus one.
// [RULE3] Multiplier writes are ignored while PLL select is set; reads always work.
// [RULE4] Divider writes are ignored while PLL select is set; reads always work.
// [RULE5] An accepted multiplier or divider write restarts lock and track detection.
// [RULE6] With PLL selected, bus rate is PLL rate divided by two.
// [RULE7] PLL rate never drops below the self-clock minimum rate.
// [RULE8] Factory test flags read zero and ignore writes outside special mode.
// [RULE9] Force/bypass and test control are factory-only like the test flags.
// [RULE10] Periodic flag bit 7 sets each interval, clears on write 1.
// [RULE11] Power-on flag bit 6 set by power-on reset, survives system reset.
// [RULE12] Low-voltage flag bit 5 set on low-voltage reset, zero when feature absent.
// [RULE13] Lock-change flag bit 4 sets on any lock status change, clears on 1.
// [RULE14] Lock status bit 3 follows detector, forced zero in self-clock mode.
// [RULE15] Track status bit 2 follows detector, forced zero in self-clock mode.
// [RULE16] Self-clock change flag bit 1 sets on status change, clears on 1.
// [RULE17] Bit 0 reads one in self-clock mode, zero with oscillator present.
// [RULE18] Twelve registers decode at module offsets 0x0 through 0xb.
// [RULE19] Watchdog service accepts byte writes and always reads zero.
// [RULE20] Enable register bits 7, 4 and 1 gate the three interrupting flags.
// [RULE21] Level interrupt while any enabled interrupting flag is set.
// [RULE22] Unimplemented bits read zero and ignore writes.
module clock_gen_register_bank #(
  parameter int FREQ_W = 16,
  parameter int SELFCLOCK_KHZ = 1000,
  parameter bit LOW_VOLTAGE_PRESENT = 1'b1
) (
  // Clock and resets
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic por_n_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // Chip mode and events
  input wire logic special_mode_i,
  input wire logic periodic_tick_i,
  input wire logic low_voltage_event_i,
  input wire logic selfclock_mode_i,
  // PLL detector and rate inputs
  input wire logic pll_lock_raw_i,
  input wire logic pll_track_raw_i,
  input wire logic [FREQ_W-1:0] osc_freq_khz_i,
  // Clock control outputs
  output logic [FREQ_W+7:0] pll_freq_khz_o,
  output logic [FREQ_W-1:0] ref_freq_khz_o,
  output logic [FREQ_W+6:0] bus_freq_khz_o,
  output logic pll_source_select_o,
  output logic detector_reinit_o,
  output logic [7:0] pll_control_o,
  output logic [7:0] clock_source_select_o,
  output logic [7:0] periodic_irq_control_o,
  output logic [7:0] watchdog_control_o,
  output logic watchdog_service_o,
  output logic [7:0] watchdog_service_data_o,
  output logic [7:0] factory_force_bypass_o,
  output logic [7:0] factory_test_control_o,
  output logic irq_o
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  initial begin
    if (FREQ_W < 8 || FREQ_W > 24) begin
      $error("FREQ_W must lie between 8 and 24");
    end
    if (SELFCLOCK_KHZ < 1 || SELFCLOCK_KHZ >= (1 << FREQ_W)) begin
      $error("SELFCLOCK_KHZ must fit in FREQ_W bits");
    end
  end

  localparam logic [FREQ_W+7:0] SELFCLOCK_FREQ = (FREQ_W+8)'(SELFCLOCK_KHZ);

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [clock_reset_gen_pkg::MULT_W-1:0] pll_multiplier;
  logic [clock_reset_gen_pkg::REFDIV_W-1:0] pll_ref_divider;
  logic [7:0] factory_test_flags;
  logic [7:0] factory_force_bypass;
  logic [7:0] factory_test_control;
  logic [7:0] clock_irq_enable;
  logic [7:0] clock_source_select;
  logic [7:0] pll_control;
  logic [7:0] periodic_irq_control;
  logic [7:0] watchdog_control;
  logic periodic_irq_flag;
  logic power_on_flag;
  logic low_voltage_flag;
  logic pll_lock_change_flag;
  logic selfclock_change_flag;
  logic lock_status;
  logic track_status;
  logic selfclock_status;

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire sel_mult = (addr_i == clock_reset_gen_pkg::OFS_PLL_MULTIPLIER); // RULE18
  wire sel_refdiv = (addr_i == clock_reset_gen_pkg::OFS_PLL_REF_DIVIDER);
  wire sel_tflags = (addr_i == clock_reset_gen_pkg::OFS_FACTORY_TEST_FLAGS);
  wire sel_flags = (addr_i == clock_reset_gen_pkg::OFS_CLOCK_FLAGS);
  wire sel_irqen = (addr_i == clock_reset_gen_pkg::OFS_CLOCK_IRQ_ENABLE);
  wire sel_clock_source_select = (addr_i == clock_reset_gen_pkg::OFS_CLOCK_SOURCE_SELECT);
  wire sel_pll_control = (addr_i == clock_reset_gen_pkg::OFS_PLL_CONTROL);
  wire sel_periodic_irq_control = (addr_i == clock_reset_gen_pkg::OFS_PERIODIC_IRQ_CONTROL);
  wire sel_wdctl = (addr_i == clock_reset_gen_pkg::OFS_WATCHDOG_CONTROL);
  wire sel_factory_force_bypass = (addr_i == clock_reset_gen_pkg::OFS_FACTORY_FORCE_BYPASS);
  wire sel_tctl = (addr_i == clock_reset_gen_pkg::OFS_FACTORY_TEST_CONTROL);
  wire sel_wdsvc = (addr_i == clock_reset_gen_pkg::OFS_WATCHDOG_SERVICE);

  wire pll_sel = clock_source_select[clock_reset_gen_pkg::BIT_PLL_SOURCE_SELECT];
  wire wr_mult = wr_i && sel_mult && !pll_sel; // RULE3
  wire wr_refdiv = wr_i && sel_refdiv && !pll_sel; // RULE4
  wire detector_reinit = wr_mult || wr_refdiv; // RULE5
  wire wr_flags = wr_i && sel_flags;
  wire wr_test = wr_i && special_mode_i; // RULE8 RULE9

  // PLL select may only be raised once the PLL is stable.
  wire pll_auto = pll_control[clock_reset_gen_pkg::BIT_PLL_AUTO];
  wire pll_stable = pll_auto ? lock_status : track_status;
  wire sel_write_ok = !wdata_i[clock_reset_gen_pkg::BIT_PLL_SOURCE_SELECT] || pll_stable;
  wire [7:0] next_clock_source_select = {
    wdata_i[clock_reset_gen_pkg::BIT_PLL_SOURCE_SELECT] && sel_write_ok && !selfclock_mode_i,
    wdata_i[6:0]};

  // ----------------------------------------------------------------
  // Status bits and change flags
  // ----------------------------------------------------------------
  wire next_lock_status = !selfclock_mode_i && !detector_reinit && pll_lock_raw_i; // RULE14
  wire next_track_status = !selfclock_mode_i && !detector_reinit && pll_track_raw_i; // RULE15
  wire lock_changed = (next_lock_status != lock_status); // RULE13
  wire selfclock_changed = (selfclock_mode_i != selfclock_status); // RULE16

  // Setting wins over a clear by write in the same cycle.
  wire next_periodic_irq_flag = periodic_tick_i ||
    (periodic_irq_flag && !(wr_flags && wdata_i[clock_reset_gen_pkg::BIT_PERIODIC_FLAG]));
  wire next_lock_change_flag = lock_changed ||
    (pll_lock_change_flag && !(wr_flags && wdata_i[clock_reset_gen_pkg::BIT_LOCK_CHANGE_FLAG]));
  wire next_selfclock_change_flag = selfclock_changed ||
    (selfclock_change_flag &&
     !(wr_flags && wdata_i[clock_reset_gen_pkg::BIT_SELFCLOCK_CHANGE_FLAG]));
  wire next_power_on_flag = power_on_flag &&
    !(wr_flags && wdata_i[clock_reset_gen_pkg::BIT_POWER_ON_FLAG]);
  wire next_low_voltage_flag = LOW_VOLTAGE_PRESENT && (low_voltage_event_i ||
    (low_voltage_flag && !(wr_flags && wdata_i[clock_reset_gen_pkg::BIT_LOW_VOLTAGE_FLAG])));

  wire [7:0] clock_flags = {periodic_irq_flag, power_on_flag, low_voltage_flag,
    pll_lock_change_flag, lock_status, track_status, selfclock_change_flag,
    selfclock_status};

  // ----------------------------------------------------------------
  // Read multiplexer
  // ----------------------------------------------------------------
  wire [7:0] test_view_flags = special_mode_i ? factory_test_flags : 8'h00; // RULE8
  wire [7:0] test_view_bypass = special_mode_i ? factory_force_bypass : 8'h00; // RULE9
  wire [7:0] test_view_control = special_mode_i ? factory_test_control : 8'h00;
  logic [7:0] read_value;
  always_comb begin
    if (sel_mult) begin
      read_value = {2'b00, pll_multiplier}; // RULE22
    end else if (sel_refdiv) begin
      read_value = {4'h0, pll_ref_divider};
    end else if (sel_tflags) begin
      read_value = test_view_flags;
    end else if (sel_flags) begin
      read_value = clock_flags; // RULE17
    end else if (sel_irqen) begin
      read_value = clock_irq_enable;
    end else if (sel_clock_source_select) begin
      read_value = clock_source_select;
    end else if (sel_pll_control) begin
      read_value = pll_control;
    end else if (sel_periodic_irq_control) begin
      read_value = periodic_irq_control;
    end else if (sel_wdctl) begin
      read_value = watchdog_control;
    end else if (sel_factory_force_bypass) begin
      read_value = test_view_bypass;
    end else if (sel_tctl) begin
      read_value = test_view_control;
    end else begin
      read_value = 8'h00; // RULE19
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= rd_i ? read_value : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pll_multiplier <= '0;
      pll_ref_divider <= '0;
    end else begin
      if (wr_mult) begin
        pll_multiplier <= wdata_i[clock_reset_gen_pkg::MULT_W-1:0]; // RULE3 RULE22
      end
      if (wr_refdiv) begin
        pll_ref_divider <= wdata_i[clock_reset_gen_pkg::REFDIV_W-1:0]; // RULE4 RULE22
      end
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clock_irq_enable <= clock_reset_gen_pkg::RST_REG;
      pll_control <= clock_reset_gen_pkg::RST_PLL_CONTROL;
      periodic_irq_control <= clock_reset_gen_pkg::RST_REG;
      watchdog_control <= clock_reset_gen_pkg::RST_REG;
    end else if (wr_i) begin
      if (sel_irqen) begin
        clock_irq_enable <= wdata_i & clock_reset_gen_pkg::MASK_IRQ_ENABLE; // RULE20
      end
      if (sel_pll_control) begin
        pll_control <= wdata_i & clock_reset_gen_pkg::MASK_PLL_CONTROL; // RULE22
      end
      if (sel_periodic_irq_control) begin
        periodic_irq_control <= wdata_i & clock_reset_gen_pkg::MASK_PERIODIC_CONTROL;
      end
      if (sel_wdctl) begin
        watchdog_control <= wdata_i & clock_reset_gen_pkg::MASK_WATCHDOG_CONTROL;
      end
    end
  end

  // Self-clock mode drops the PLL selection.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      clock_source_select <= clock_reset_gen_pkg::RST_REG;
    end else if (wr_i && sel_clock_source_select) begin
      clock_source_select <= next_clock_source_select;
    end else if (selfclock_mode_i) begin
      clock_source_select[clock_reset_gen_pkg::BIT_PLL_SOURCE_SELECT] <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      factory_test_flags <= clock_reset_gen_pkg::RST_REG;
      factory_force_bypass <= clock_reset_gen_pkg::RST_REG;
      factory_test_control <= clock_reset_gen_pkg::RST_REG;
    end else if (wr_test) begin
      if (sel_tflags) begin
        factory_test_flags <= wdata_i; // RULE8
      end
      if (sel_factory_force_bypass) begin
        factory_force_bypass <= wdata_i; // RULE9
      end
      if (sel_tctl) begin
        factory_test_control <= wdata_i; // RULE9
      end
    end
  end

  // ----------------------------------------------------------------
  // Flags and status
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      periodic_irq_flag <= 1'b0;
      pll_lock_change_flag <= 1'b0;
      selfclock_change_flag <= 1'b0;
      lock_status <= 1'b0;
      track_status <= 1'b0;
      selfclock_status <= 1'b0;
    end else begin
      periodic_irq_flag <= next_periodic_irq_flag; // RULE10
      pll_lock_change_flag <= next_lock_change_flag; // RULE13
      selfclock_change_flag <= next_selfclock_change_flag; // RULE16
      lock_status <= next_lock_status; // RULE5 RULE14
      track_status <= next_track_status; // RULE5 RULE15
      selfclock_status <= selfclock_mode_i; // RULE17
    end
  end

  // These two flags live on the power-on reset only, so system reset keeps them.
  always_ff @(posedge clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      power_on_flag <= 1'b1; // RULE11
      low_voltage_flag <= 1'b0;
    end else begin
      power_on_flag <= next_power_on_flag; // RULE11
      low_voltage_flag <= next_low_voltage_flag; // RULE12
    end
  end

  // ----------------------------------------------------------------
  // Rate arithmetic
  // ----------------------------------------------------------------
  wire [FREQ_W+7:0] pll_product = (FREQ_W+8)'({osc_freq_khz_i, 1'b0} *
    ({1'b0, pll_multiplier} + 7'h01));
  wire [FREQ_W+7:0] pll_quotient = pll_product / ({1'b0, pll_ref_divider} + 5'h01); // RULE1
  wire [FREQ_W+7:0] pll_rate = selfclock_mode_i || (pll_quotient < SELFCLOCK_FREQ) ?
    SELFCLOCK_FREQ : pll_quotient; // RULE7
  wire [FREQ_W-1:0] ref_rate = FREQ_W'(osc_freq_khz_i /
    ({1'b0, pll_ref_divider} + 5'h01)); // RULE2
  wire [FREQ_W+6:0] bus_rate = pll_sel ? pll_rate[FREQ_W+7:1] :
    (FREQ_W+7)'(osc_freq_khz_i[FREQ_W-1:1]); // RULE6

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pll_freq_khz_o <= '0;
      ref_freq_khz_o <= '0;
      bus_freq_khz_o <= '0;
    end else begin
      pll_freq_khz_o <= pll_rate;
      ref_freq_khz_o <= ref_rate;
      bus_freq_khz_o <= bus_rate;
    end
  end

  // ----------------------------------------------------------------
  // Watchdog service and pulses
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      watchdog_service_o <= 1'b0;
      watchdog_service_data_o <= 8'h00;
      detector_reinit_o <= 1'b0;
    end else begin
      watchdog_service_o <= wr_i && sel_wdsvc; // RULE19
      if (wr_i && sel_wdsvc) begin
        watchdog_service_data_o <= wdata_i;
      end
      detector_reinit_o <= detector_reinit; // RULE5
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign irq_o = (periodic_irq_flag &&
                  clock_irq_enable[clock_reset_gen_pkg::BIT_PERIODIC_ENABLE]) ||
                 (pll_lock_change_flag &&
                  clock_irq_enable[clock_reset_gen_pkg::BIT_LOCK_CHANGE_ENABLE]) ||
                 (selfclock_change_flag &&
                  clock_irq_enable[clock_reset_gen_pkg::BIT_SELFCLOCK_CHANGE_ENABLE]); // RULE21
  assign pll_source_select_o = pll_sel;
  assign pll_control_o = pll_control;
  assign clock_source_select_o = clock_source_select;
  assign periodic_irq_control_o = periodic_irq_control;
  assign watchdog_control_o = watchdog_control;
  assign factory_force_bypass_o = test_view_bypass;
  assign factory_test_control_o = test_view_control;

endmodule

// ===== clock_gen_register_bank_assertions.sv
// Checker of the port behaviour of the clock register bank.
`timescale 1ns/100ps
module clock_gen_register_bank_checker #(
  parameter int FREQ_W = 16,
  parameter int SELFCLOCK_KHZ = 1000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // Register port
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  // Mode and rates
  input wire logic special_mode_i,
  input wire logic selfclock_mode_i,
  input wire logic [FREQ_W-1:0] osc_freq_khz_i,
  input wire logic [FREQ_W+7:0] pll_freq_khz_o,
  input wire logic [FREQ_W+6:0] bus_freq_khz_o,
  // Control outputs
  input wire logic pll_source_select_o,
  input wire logic detector_reinit_o,
  input wire logic watchdog_service_o,
  input wire logic [7:0] watchdog_service_data_o,
  input wire logic [7:0] factory_force_bypass_o,
  input wire logic [7:0] factory_test_control_o
);
  default clocking dc @(posedge clk_i);
  endclocking
  default disable iff (!arst_n_i);

  a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside the read slot");
  a_unmapped_zero: assert property (rd_i && addr_i >= 4'hc |=> rdata_o == 8'h00)
    else $error("unmapped offset did not read zero");
  a_service_reads_zero: assert property (rd_i && addr_i == 4'hb |=> rdata_o == 8'h00)
    else $error("watchdog service register did not read zero");
  a_service_pulse: assert property (wr_i && addr_i == 4'hb |=> watchdog_service_o &&
    watchdog_service_data_o == $past(wdata_i))
    else $error("watchdog service write not passed on");
  a_reinit_accept: assert property (wr_i && addr_i[3:1] == 3'b000 && !pll_source_select_o
    |=> detector_reinit_o)
    else $error("accepted rate write did not restart detection");
  a_reinit_locked: assert property (wr_i && addr_i[3:1] == 3'b000 && pll_source_select_o
    |=> !detector_reinit_o)
    else $error("refused rate write restarted detection");
  a_factory_hidden: assert property (!special_mode_i |-> factory_force_bypass_o == 8'h00 &&
    factory_test_control_o == 8'h00)
    else $error("factory register visible outside special mode");
  a_bus_from_pll: assert property ((pll_source_select_o && $stable(pll_freq_khz_o))[*3]
    |-> bus_freq_khz_o == (pll_freq_khz_o >> 1))
    else $error("bus rate not half the pll rate");
  a_bus_from_osc: assert property ((!pll_source_select_o && $stable(osc_freq_khz_i))[*3]
    |-> bus_freq_khz_o == (osc_freq_khz_i >> 1))
    else $error("bus rate not half the oscillator rate");
  a_pll_floor: assert property (1'b1 |-> ##2 pll_freq_khz_o >= SELFCLOCK_KHZ)
    else $error("pll rate below the self-clock rate");
  a_selfclock_rate: assert property (selfclock_mode_i[*3] |-> pll_freq_khz_o == SELFCLOCK_KHZ)
    else $error("pll rate not at minimum in self-clock mode");
endmodule

bind clock_gen_register_bank clock_gen_register_bank_checker #(.FREQ_W(FREQ_W),
  .SELFCLOCK_KHZ(SELFCLOCK_KHZ)) chk_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .special_mode_i(special_mode_i),
  .selfclock_mode_i(selfclock_mode_i), .osc_freq_khz_i(osc_freq_khz_i),
  .pll_freq_khz_o(pll_freq_khz_o), .bus_freq_khz_o(bus_freq_khz_o),
  .pll_source_select_o(pll_source_select_o), .detector_reinit_o(detector_reinit_o),
  .watchdog_service_o(watchdog_service_o), .watchdog_service_data_o(watchdog_service_data_o),
  .factory_force_bypass_o(factory_force_bypass_o),
  .factory_test_control_o(factory_test_control_o));

// ===== tb.sv
// Self-checking testbench of the clock register bank.
`timescale 1ns/100ps
module tb;
  logic clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic por_n_i = 1'b0;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic special_mode_i = 1'b0;
  logic periodic_tick_i = 1'b0;
  logic low_voltage_event_i = 1'b0;
  logic selfclock_mode_i = 1'b0;
  logic pll_lock_raw_i = 1'b0;
  logic pll_track_raw_i = 1'b0;
  logic [15:0] osc_freq_khz_i = 16'h1f40;
  logic [7:0] rdata_o, watchdog_service_data_o, factory_force_bypass_o, factory_test_control_o;
  logic [7:0] pll_control_o, clock_source_select_o, periodic_irq_control_o, watchdog_control_o;
  logic [23:0] pll_freq_khz_o;
  logic [15:0] ref_freq_khz_o;
  logic [22:0] bus_freq_khz_o;
  logic pll_source_select_o, detector_reinit_o, watchdog_service_o, irq_o;
  logic [31:0] seed = 32'h5;
  logic [3:0] fac [3] = '{4'h2, 4'h9, 4'ha};
  logic [7:0] masks [3] = '{8'hf7, 8'h7f, 8'hc7};
  int fails = 0;
  int samples_checked = 0;
  int mult = 0;
  int div = 0;
  int osc = 8000;
  int sel = 0;

  always #20 clk_i = ~clk_i;

  clock_gen_register_bank dut_u (.clk_i(clk_i), .arst_n_i(arst_n_i), .por_n_i(por_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .special_mode_i(special_mode_i), .periodic_tick_i(periodic_tick_i),
    .low_voltage_event_i(low_voltage_event_i), .selfclock_mode_i(selfclock_mode_i),
    .pll_lock_raw_i(pll_lock_raw_i), .pll_track_raw_i(pll_track_raw_i),
    .osc_freq_khz_i(osc_freq_khz_i), .pll_freq_khz_o(pll_freq_khz_o),
    .ref_freq_khz_o(ref_freq_khz_o), .bus_freq_khz_o(bus_freq_khz_o),
    .pll_source_select_o(pll_source_select_o), .detector_reinit_o(detector_reinit_o),
    .pll_control_o(pll_control_o), .clock_source_select_o(clock_source_select_o),
    .periodic_irq_control_o(periodic_irq_control_o), .watchdog_control_o(watchdog_control_o),
    .watchdog_service_o(watchdog_service_o), .watchdog_service_data_o(watchdog_service_data_o),
    .factory_force_bypass_o(factory_force_bypass_o),
    .factory_test_control_o(factory_test_control_o), .irq_o(irq_o));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  function automatic void step_rand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1;
    check(rdata_o, exp);
  endtask

  task automatic check_rates;
    int p;
    repeat (3) @(posedge clk_i);
    #1;
    p = 2 * osc * (mult + 1) / (div + 1);
    if (selfclock_mode_i || p < 1000) begin
      p = 1000;
    end
    check(pll_freq_khz_o, p);
    check(ref_freq_khz_o, osc / (div + 1));
    check(bus_freq_khz_o, (sel != 0) ? p / 2 : osc / 2);
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    #(40 * 5000);
    fails++;
    report_and_stop;
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    por_n_i <= 1'b1;
    rd(4'h3, 8'h40);
    for (int i = 0; i < 5; i++) begin
      step_rand();
      @(posedge clk_i);
      osc = (i == 0) ? 4000 : 1 + int'(seed[13:0]);
      osc_freq_khz_i <= osc[15:0];
      wr(4'h0, (i == 0) ? 8'hc0 : seed[7:0]);
      wr(4'h1, (i == 0) ? 8'hff : seed[15:8]);
      mult = (i == 0) ? 0 : int'(seed[5:0]);
      div = (i == 0) ? 15 : int'(seed[11:8]);
      rd(4'h0, mult[7:0]);
      rd(4'h1, div[7:0]);
      check_rates;
    end
    @(posedge clk_i);
    pll_lock_raw_i <= 1'b1;
    pll_track_raw_i <= 1'b1;
    rd(4'h3, 8'h5c);
    wr(4'h3, 8'h10);
    rd(4'h3, 8'h4c);
    wr(4'h5, 8'h80);
    sel = 1;
    rd(4'h5, 8'h80);
    check_rates;
    wr(4'h0, 8'h3f ^ mult[7:0]);
    wr(4'h1, 8'h0f ^ div[7:0]);
    rd(4'h0, mult[7:0]);
    rd(4'h1, div[7:0]);
    rd(4'h3, 8'h4c);
    wr(4'h5, 8'h00);
    sel = 0;
    wr(4'h0, 8'h01);
    mult = 1;
    rd(4'h3, 8'h5c);
    check_rates;
    wr(4'h4, 8'hff);
    rd(4'h4, 8'h92);
    check(irq_o, 1'b1);
    wr(4'h3, 8'h10);
    #1;
    check(irq_o, 1'b0);
    @(posedge clk_i);
    periodic_tick_i <= 1'b1;
    @(posedge clk_i);
    periodic_tick_i <= 1'b0;
    #1;
    check(irq_o, 1'b1);
    wr(4'h4, 8'h12);
    #1;
    check(irq_o, 1'b0);
    wr(4'h3, 8'h00);
    rd(4'h3, 8'hcc);
    wr(4'h3, 8'h80);
    rd(4'h3, 8'h4c);
    @(posedge clk_i);
    selfclock_mode_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(4'h3, 8'h53);
    check(irq_o, 1'b1);
    check_rates;
    @(posedge clk_i);
    selfclock_mode_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd(4'h3, 8'h5e);
    wr(4'h3, 8'h12);
    rd(4'h3, 8'h4c);
    @(posedge clk_i);
    low_voltage_event_i <= 1'b1;
    @(posedge clk_i);
    low_voltage_event_i <= 1'b0;
    rd(4'h3, 8'h6c);
    @(posedge clk_i);
    arst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    arst_n_i <= 1'b1;
    rd(4'h3, 8'h7c);
    wr(4'h3, 8'h70);
    rd(4'h3, 8'h0c);
    for (int i = 0; i < 3; i++) begin
      wr(fac[i], 8'ha5);
      rd(fac[i], 8'h00);
      @(posedge clk_i);
      special_mode_i <= 1'b1;
      wr(fac[i], 8'h5a);
      rd(fac[i], 8'h5a);
      @(posedge clk_i);
      special_mode_i <= 1'b0;
      rd(fac[i], 8'h00);
      wr(4'h6 + 4'(i), 8'hff);
      rd(4'h6 + 4'(i), masks[i]);
    end
    check(pll_control_o, 8'hf7);
    check(periodic_irq_control_o, 8'h7f);
    check(watchdog_control_o, 8'hc7);
    @(posedge clk_i);
    pll_lock_raw_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    wr(4'h5, 8'hff);
    rd(4'h5, 8'h7f);
    check(clock_source_select_o, 8'h7f);
    check(pll_source_select_o, 1'b0);
    step_rand();
    wr(4'hb, seed[7:0]);
    rd(4'hb, 8'h00);
    rd(4'hc, 8'h00);
    rd(4'hf, 8'h00);
    report_and_stop;
  end
endmodule
